// *** include/tss_pkg.sv ***
package tss_pkg;
  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [13:0] IDX_CAL_HI = 14'h230a;
  localparam logic [13:0] IDX_CAL_LO = 14'h230b;
  localparam logic [13:0] IDX_TEST_MUX_A_SELECT_A = 14'h2502;
  localparam logic [13:0] IDX_TEST_MUX_A_SELECT_B = 14'h2503;
  localparam logic [13:0] IDX_REF = 14'h2704;
  localparam logic [13:0] IDX_REV = 14'h2706;
  localparam logic [13:0] IDX_RMUX = 14'h270a;
  localparam logic [13:0] IDX_RES_HI = 14'h2881;
  localparam logic [13:0] IDX_RES_LO = 14'h2882;
  localparam logic [13:0] IDX_CTRL = 14'h28a0;
  localparam logic [13:0] IDX_CMD = 14'h28b4;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_BSEL = 7;
  localparam int CTRL_PWR = 6;
  localparam int CTRL_BAT = 4;
  localparam int CTRL_BUSY = 3;
  localparam int CMD_START = 6;
  localparam int REF_OUT = 7;
  localparam int REF_DIS = 6;
  // ----------------------------------------------------------------
  // Period codes, reset and wake values
  // ----------------------------------------------------------------
  localparam logic [2:0] PER_OFF = 3'h0;
  localparam logic [2:0] PER_CONT = 3'h7;
  localparam logic [2:0] RMUX_RST = 3'h0;
  localparam logic [5:0] TEST_MUX_A_SELECT_A_RST = 6'h00;
  localparam logic [4:0] TEST_MUX_A_SELECT_B_RST = 5'h00;
  localparam logic REF_DIS_RST = 1'b0;
  localparam logic REF_DIS_WAKE = 1'b1;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 10;
  localparam int BUSY_MS = 6;
  localparam int TICK_S = 1;
  localparam int BUSY_CYC = BUSY_MS * 1000000 / CLK_NS;
  localparam int TICK_CYC = TICK_S * 1000000000 / CLK_NS;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic bsel;
    logic pwr;
    logic bat;
    logic [2:0] per;
  } tss_ctrl_t;
  typedef struct packed {
    logic sleep_mode;
    logic display_only_mode;
  } tss_mode_t;
  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_MEAS} tss_state_t;
endpackage : tss_pkg

// *** rtl/tss_ctrl.sv ***
`timescale 1ns/1ps
// Overview of operation
// - Period code: 0 off, 1-6 timed, 7 continuous
// - Automatic measurements run in every mode
// - One-shot start only when period is zero
// - One-shot ignored in sleep and display modes
// - Start bit self-clears when measurement done
// - Busy flag locks control byte writes
// - Battery measured along with temperature
// - Battery select: 1 main, 0 clock battery
// - Supply select: 1 digital, 0 clock battery
// - Sleep/display force clock battery supply
// - Read-only 11-bit calibration value at 22C
// - Test mux A picks one of 32
// - Test mux B picks one of 32
// - Remote sensor mux zero on reset, wake
// - Read-only silicon revision code
// - Reference output unless reference disabled
// - Reference disable: 0 reset, 1 wake
// - Result split upper eight, lower three bits
module tss_ctrl #(
  parameter int BUSY_CYC = tss_pkg::BUSY_CYC,
  parameter int TICK_CYC = tss_pkg::TICK_CYC,
  parameter logic [7:0] REVISION = 8'h5a // Arbitrary value
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Power mode and wake, same clock
  input wire tss_pkg::tss_mode_t mode,
  input wire logic wake,
  // Analog sensor side, asynchronous
  input wire logic meas_done,
  input wire logic [10:0] sensor_result,
  input wire logic [10:0] cal_value,
  output logic meas_start,
  output logic meas_battery,
  output logic monitored_battery_select,
  output logic sensor_supply_select,
  // Test multiplexers
  input wire logic [31:0] test_mux_a_in,
  input wire logic [31:0] test_mux_b_in,
  output logic test_mux_a_out,
  output logic test_mux_b_out,
  output logic [2:0] remote_sensor_mux_select,
  // Voltage reference
  output logic reference_out_en,
  output logic reference_disable
);
  // Counters are 23 and 27 bits wide; refuse counts they cannot hold
  if (BUSY_CYC < 2 || BUSY_CYC > 8388608 || TICK_CYC < 2 ||
      TICK_CYC > 134217728) begin : g_bad_counts
    $error("tss_ctrl: count parameters out of range");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Word-aligned index of an address, or all ones when above the low 64 KB or misaligned
  function automatic logic [13:0] addr_idx(input logic [31:0] a);
    addr_idx = (a[31:16] == 16'h0000 && a[1:0] == 2'b00) ?
      a[15:2] : 14'h3fff;
  endfunction : addr_idx

  // Number of ticks in one period for codes 1 to 6
  function automatic logic [9:0] period_ticks(input logic [2:0] p);
    period_ticks = 10'h008 << p;
  endfunction : period_ticks

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  tss_pkg::tss_ctrl_t ctrl_reg; // Control byte fields
  logic busy_reg; // Control byte update in progress
  logic [22:0] busy_cnt_reg; // Lockout countdown
  logic start_reg; // One-shot start bit
  logic [5:0] test_mux_a_select_a_reg;
  logic [4:0] test_mux_a_select_b_reg;
  logic [2:0] rmux_reg;
  logic ref_out_reg;
  logic ref_dis_reg;
  logic [10:0] result_reg; // Last completed result
  logic [26:0] sec_cnt_reg; // Cycles within one second
  logic [9:0] tick_cnt_reg; // Seconds within one period
  tss_pkg::tss_state_t state_reg;
  logic wr_pend_reg; // Write data phase pending
  logic [13:0] wr_idx_reg;
  logic done_s1_reg, done_s2_reg, done_s3_reg; // Done synchroniser
  logic [10:0] res_s1_reg, res_s2_reg; // Result synchroniser
  logic [10:0] cal_s1_reg, cal_s2_reg; // Calibration synchroniser
  logic low_power; // Sleep or display-only
  logic done_rise;
  logic per_due;
  logic sec_tick;
  logic addr_ok;
  logic ctrl_wr, cmd_wr;
  logic [7:0] rd_byte;

  assign low_power = mode.sleep_mode | mode.display_only_mode;
  assign addr_ok = hsel & hready & htrans[1];
  assign done_rise = done_s2_reg & ~done_s3_reg;
  assign ctrl_wr = wr_pend_reg & (wr_idx_reg == tss_pkg::IDX_CTRL);
  assign cmd_wr = wr_pend_reg & (wr_idx_reg == tss_pkg::IDX_CMD);
  assign sec_tick = (sec_cnt_reg == 27'(TICK_CYC - 1));

  // ----------------------------------------------------------------
  // Synchronisers for analog inputs
  // ----------------------------------------------------------------
  // Result is stable when done rises, so a plain two-stage copy is safe
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      done_s1_reg <= 1'b0;
      done_s2_reg <= 1'b0;
      done_s3_reg <= 1'b0;
      res_s1_reg <= 11'h000;
      res_s2_reg <= 11'h000;
      cal_s1_reg <= 11'h000;
      cal_s2_reg <= 11'h000;
    end else begin
      done_s1_reg <= meas_done;
      done_s2_reg <= done_s1_reg;
      done_s3_reg <= done_s2_reg;
      res_s1_reg <= sensor_result;
      res_s2_reg <= res_s1_reg;
      cal_s1_reg <= cal_value;
      cal_s2_reg <= cal_s1_reg;
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave: zero wait, always OKAY
  // ----------------------------------------------------------------
  // Address phase capture for writes
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= 14'h0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend_reg <= addr_ok & hwrite;
      wr_idx_reg <= addr_idx(haddr);
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Read decode, unmapped words read zero
  always_comb begin
    unique case (addr_idx(haddr))
      tss_pkg::IDX_CAL_HI: rd_byte = {5'h00, cal_s2_reg[10:8]};
      tss_pkg::IDX_CAL_LO: rd_byte = cal_s2_reg[7:0];
      tss_pkg::IDX_TEST_MUX_A_SELECT_A: rd_byte = {2'b00, test_mux_a_select_a_reg};
      tss_pkg::IDX_TEST_MUX_A_SELECT_B: rd_byte = {3'b000, test_mux_a_select_b_reg};
      tss_pkg::IDX_REF: rd_byte = {ref_out_reg, ref_dis_reg, 6'h00};
      tss_pkg::IDX_REV: rd_byte = REVISION;
      tss_pkg::IDX_RMUX: rd_byte = {5'h00, rmux_reg};
      tss_pkg::IDX_RES_HI: rd_byte = result_reg[10:3];
      tss_pkg::IDX_RES_LO: rd_byte = {result_reg[2:0], 5'h00};
      tss_pkg::IDX_CTRL: rd_byte = {ctrl_reg.bsel, ctrl_reg.pwr, 1'b0,
        ctrl_reg.bat, busy_reg, ctrl_reg.per};
      tss_pkg::IDX_CMD: rd_byte = {1'b0, start_reg, 6'h00};
      default: rd_byte = 8'h00;
    endcase
  end

  // Read data is registered into the data phase
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok & ~hwrite) begin
      hrdata <= {24'h00_0000, rd_byte};
    end
  end

  // ----------------------------------------------------------------
  // Control byte and busy lockout
  // ----------------------------------------------------------------
  // lockout while busy
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= '0;
      busy_reg <= 1'b0;
      busy_cnt_reg <= 23'h00_0000;
    end else if (ctrl_wr & ~busy_reg) begin
      ctrl_reg.bsel <= hwdata[tss_pkg::CTRL_BSEL];
      ctrl_reg.pwr <= hwdata[tss_pkg::CTRL_PWR];
      ctrl_reg.bat <= hwdata[tss_pkg::CTRL_BAT];
      ctrl_reg.per <= hwdata[2:0];
      busy_reg <= 1'b1;
      busy_cnt_reg <= 23'(BUSY_CYC - 1);
    end else if (busy_reg) begin
      busy_cnt_reg <= busy_cnt_reg - 23'h00_0001;
      busy_reg <= (busy_cnt_reg != 23'h00_0000);
    end
  end

  // ----------------------------------------------------------------
  // Other software registers
  // ----------------------------------------------------------------
  // Wake forces its own values; writes win otherwise
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      test_mux_a_select_a_reg <= tss_pkg::TEST_MUX_A_SELECT_A_RST;
      test_mux_a_select_b_reg <= tss_pkg::TEST_MUX_A_SELECT_B_RST;
      rmux_reg <= tss_pkg::RMUX_RST;
      ref_out_reg <= 1'b0;
      ref_dis_reg <= tss_pkg::REF_DIS_RST;
    end else if (wake) begin
      rmux_reg <= tss_pkg::RMUX_RST;
      ref_dis_reg <= tss_pkg::REF_DIS_WAKE;
    end else if (wr_pend_reg) begin
      case (wr_idx_reg)
        tss_pkg::IDX_TEST_MUX_A_SELECT_A: test_mux_a_select_a_reg <= hwdata[5:0];
        tss_pkg::IDX_TEST_MUX_A_SELECT_B: test_mux_a_select_b_reg <= hwdata[4:0];
        tss_pkg::IDX_RMUX: rmux_reg <= hwdata[2:0];
        tss_pkg::IDX_REF: begin
          ref_out_reg <= hwdata[tss_pkg::REF_OUT];
          ref_dis_reg <= hwdata[tss_pkg::REF_DIS];
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // One-shot start bit
  // ----------------------------------------------------------------
  // A write of one in a low-power mode is dropped rather than parked,
  // so no stale request fires when the mode ends.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      start_reg <= 1'b0;
    end else if (cmd_wr & hwdata[tss_pkg::CMD_START] & ~low_power &
                 (ctrl_reg.per == tss_pkg::PER_OFF)) begin
      start_reg <= 1'b1;
    end else if (state_reg == tss_pkg::ST_MEAS && done_rise) begin
      start_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Period timer
  // ----------------------------------------------------------------
  // tick counter restarts on write
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sec_cnt_reg <= 27'h000_0000;
      tick_cnt_reg <= 10'h000;
    end else if (ctrl_wr & ~busy_reg) begin
      sec_cnt_reg <= 27'h000_0000;
      tick_cnt_reg <= 10'h000;
    end else if (sec_tick) begin
      sec_cnt_reg <= 27'h000_0000;
      tick_cnt_reg <= per_due ? 10'h000 : tick_cnt_reg + 10'h001;
    end else begin
      sec_cnt_reg <= sec_cnt_reg + 27'h000_0001;
    end
  end

  assign per_due = sec_tick && ctrl_reg.per != tss_pkg::PER_OFF &&
    ctrl_reg.per != tss_pkg::PER_CONT &&
    tick_cnt_reg == period_ticks(ctrl_reg.per) - 10'h001;

  // ----------------------------------------------------------------
  // Measurement scheduler
  // ----------------------------------------------------------------
  // automatic runs ignore power mode
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= tss_pkg::ST_IDLE;
      meas_start <= 1'b0;
      meas_battery <= 1'b0;
      result_reg <= 11'h000;
    end else begin
      meas_start <= 1'b0;
      meas_battery <= 1'b0;
      case (state_reg)
        tss_pkg::ST_IDLE: begin
          if (per_due || ctrl_reg.per == tss_pkg::PER_CONT ||
              (start_reg && !low_power)) begin
            state_reg <= tss_pkg::ST_START;
          end
        end
        tss_pkg::ST_START: begin
          meas_start <= 1'b1;
          meas_battery <= ctrl_reg.bat;
          state_reg <= tss_pkg::ST_MEAS;
        end
        tss_pkg::ST_MEAS: begin
          if (done_rise) begin
            result_reg <= res_s2_reg;
            state_reg <= tss_pkg::ST_IDLE;
          end
        end
        default: state_reg <= tss_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Selections and test outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      monitored_battery_select <= 1'b0;
      sensor_supply_select <= 1'b0;
      test_mux_a_out <= 1'b0;
      test_mux_b_out <= 1'b0;
      remote_sensor_mux_select <= tss_pkg::RMUX_RST;
      reference_out_en <= 1'b0;
      reference_disable <= tss_pkg::REF_DIS_RST;
    end else begin
      monitored_battery_select <= ctrl_reg.bsel;
      // supply choice, forced in low power
      sensor_supply_select <= ctrl_reg.pwr & ~low_power;
      // mux A; top select bit is stored only
      test_mux_a_out <= test_mux_a_in[test_mux_a_select_a_reg[4:0]];
      test_mux_b_out <= test_mux_b_in[test_mux_a_select_b_reg];
      remote_sensor_mux_select <= rmux_reg;
      reference_out_en <= ref_out_reg & ~ref_dis_reg;
      reference_disable <= ref_dis_reg;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence s_done_in_meas;
    state_reg == tss_pkg::ST_MEAS && done_rise;
  endsequence
  sequence s_ok_ctrl_write;
    ctrl_wr && !busy_reg;
  endsequence

  chk_lock_write: assert property (
    ctrl_wr && busy_reg |=> $stable(ctrl_reg))
    else $error("control byte changed while busy");
  chk_busy_raise: assert property (
    s_ok_ctrl_write |=> busy_reg)
    else $error("busy not raised after write");
  chk_oneshot_clear: assert property (
    s_done_in_meas and !cmd_wr |=> !start_reg)
    else $error("start bit not cleared at completion");
  chk_oneshot_lowpwr: assert property (
    state_reg == tss_pkg::ST_IDLE && low_power && !per_due &&
    ctrl_reg.per == tss_pkg::PER_OFF |=> state_reg == tss_pkg::ST_IDLE)
    else $error("one-shot started in low power");
  chk_start_pulse: assert property (
    meas_start |-> meas_battery == $past(ctrl_reg.bat) ##1 !meas_start)
    else $error("start pulse or battery flag wrong");
  chk_cont_restart: assert property (
    s_done_in_meas and ctrl_reg.per == tss_pkg::PER_CONT
    |=> ##1 state_reg == tss_pkg::ST_START)
    else $error("continuous mode did not restart");
  chk_supply_low: assert property (
    low_power |=> !sensor_supply_select)
    else $error("supply not forced in low power");
  chk_ref_out: assert property (
    reference_disable |-> !reference_out_en)
    else $error("reference output while disabled");
  chk_wake_vals: assert property (
    wake |=> ##1 remote_sensor_mux_select == 3'h0 && reference_disable)
    else $error("wake values not applied");
  chk_timer_restart: assert property (
    s_ok_ctrl_write |=> sec_cnt_reg == 27'h000_0000 &&
    tick_cnt_reg == 10'h000)
    else $error("period timer not restarted");
endmodule : tss_ctrl

// *** tb/test_temp_sensor_sched_ctrl.sv ***
`timescale 1ns/1ps
module test_temp_sensor_sched_ctrl;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int BUSY = 12; // Short lockout for simulation
  localparam int TICK = 4; // Short second for simulation
  localparam logic [7:0] REV = 8'h3c; // Arbitrary value
  logic sys_clk, rstn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, mux_a_in, mux_b_in, seen;
  logic [1:0] htrans;
  logic [2:0] hsize, rsel;
  logic [10:0] result, cal;
  tss_pkg::tss_mode_t mode;
  logic wake, meas_done, start, bat, bsel, pwr;
  logic ma_out, mb_out, ref_en, ref_dis;
  logic obs_stb, cnt_clr;
  logic [2:0] obs_sel;
  logic [15:0] start_cnt, bat_cnt;
  logic [31:0] exp_q[$];
  int num_errors, checks_done, seed, p;
  logic [5:0] sa;
  logic [4:0] sb;
  assign hready = hreadyout; // Single slave drives the bus ready

  tss_ctrl #(.BUSY_CYC(BUSY), .TICK_CYC(TICK), .REVISION(REV)) dut (
    .sys_clk(sys_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .mode(mode), .wake(wake), .meas_done(meas_done),
    .sensor_result(result), .cal_value(cal), .meas_start(start),
    .meas_battery(bat), .monitored_battery_select(bsel),
    .sensor_supply_select(pwr), .test_mux_a_in(mux_a_in),
    .test_mux_b_in(mux_b_in), .test_mux_a_out(ma_out),
    .test_mux_b_out(mb_out), .remote_sensor_mux_select(rsel),
    .reference_out_en(ref_en), .reference_disable(ref_dis));

  // ----------------------------------------------------------------
  // Clock, analog responder and pulse counters
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Slow analog side: done comes well after each start
  initial begin
    forever begin
      @(posedge sys_clk);
      if (start === 1'b1) begin
        repeat (20) @(posedge sys_clk);
        meas_done <= 1'b1;
        repeat (4) @(posedge sys_clk);
        meas_done <= 1'b0;
      end
    end
  end
  always @(posedge sys_clk) begin
    if (cnt_clr) begin
      start_cnt <= 16'h0000;
      bat_cnt <= 16'h0000;
    end else begin
      if (start === 1'b1) start_cnt <= start_cnt + 16'h0001;
      if (bat === 1'b1) bat_cnt <= bat_cnt + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------
  task check(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : check
  // Watcher takes the oldest note whenever an observation is flagged
  always @(posedge sys_clk) begin
    if (obs_stb === 1'b1) begin
      case (obs_sel)
        3'h0: seen = hrdata;
        3'h1: seen = {25'h0, pwr, bsel, ref_en, ref_dis, rsel};
        3'h2: seen = {bat_cnt, start_cnt};
        3'h3: seen = {31'h0, start_cnt >= 16'h0003};
        3'h5: seen = {30'h0, hreadyout, hresp};
        default: seen = {30'h0, ma_out, mb_out};
      endcase
      check(seen, exp_q.pop_front());
    end
  end
  task final_report;
    $display("checks %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report
  initial begin
    #400000;
    num_errors++;
    final_report();
  end

  // ----------------------------------------------------------------
  // Bus and observation tasks
  // ----------------------------------------------------------------
  task wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : wait_cyc
  // Waits as long as the slave needs; only the watchdog ends a hang
  task wait_ready;
    do begin
      @(posedge sys_clk);
    end while (hready !== 1'b1);
  endtask : wait_ready
  // One single-word transfer; on a read, d is the expected byte
  task bus(input logic w, input logic [13:0] idx, input logic [7:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {16'h0000, idx, 2'b00};
    hwrite <= w;
    hsize <= 3'b010;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= w ? {24'h00_0000, d} : 32'h0000_0000;
    if (!w) begin
      exp_q.push_back({24'h00_0000, d});
      obs_sel <= 3'h0;
      obs_stb <= 1'b1;
    end
    wait_ready();
    obs_stb <= 1'b0;
  endtask : bus
  task expect_port(input logic [2:0] sel, input logic [31:0] v);
    exp_q.push_back(v);
    @(posedge sys_clk);
    obs_sel <= sel;
    obs_stb <= 1'b1;
    @(posedge sys_clk);
    obs_stb <= 1'b0;
  endtask : expect_port
  task clear_counts;
    @(posedge sys_clk);
    cnt_clr <= 1'b1;
    @(posedge sys_clk);
    cnt_clr <= 1'b0;
  endtask : clear_counts
  task done_test(input string name);
    $display("test %0s finished, mismatches %0d", name, num_errors);
  endtask : done_test

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 12;
    num_errors = 0;
    checks_done = 0;
    {rstn, hsel, hwrite, wake, meas_done, obs_stb, cnt_clr} = 7'h01;
    {haddr, hwdata, htrans, hsize, obs_sel} = '0;
    mode = '0;
    result = 11'($random(seed));
    cal = 11'($random(seed));
    mux_a_in = $random(seed);
    mux_b_in = $random(seed);
    rstn = 1'b0;
    wait_cyc(4);
    rstn <= 1'b1;
    cnt_clr <= 1'b0;
    // Reset values, read-only words and an unmapped hole
    bus(0, tss_pkg::IDX_CTRL, 8'h00);
    bus(0, tss_pkg::IDX_CMD, 8'h00);
    bus(0, tss_pkg::IDX_REF, 8'h00);
    bus(0, tss_pkg::IDX_RMUX, 8'h00);
    bus(0, tss_pkg::IDX_CAL_HI, {5'h00, cal[10:8]});
    bus(0, tss_pkg::IDX_CAL_LO, cal[7:0]);
    bus(1, tss_pkg::IDX_REV, 8'hff);
    bus(0, tss_pkg::IDX_REV, REV);
    bus(0, 14'h0100, 8'h00);
    // Bus ready high and response OKAY
    expect_port(3'h5, 32'h0000_0002);
    done_test("reset");
    for (int i = 0; i < 6; i++) begin
      sa = 6'($random(seed));
      sb = 5'($random(seed));
      mux_a_in <= $random(seed);
      mux_b_in <= $random(seed);
      bus(1, tss_pkg::IDX_TEST_MUX_A_SELECT_A, {2'b00, sa});
      bus(1, tss_pkg::IDX_TEST_MUX_A_SELECT_B, {3'b000, sb});
      expect_port(3'h4, {30'h0, mux_a_in[sa[4:0]], mux_b_in[sb]});
      bus(0, tss_pkg::IDX_TEST_MUX_A_SELECT_A, {2'b00, sa});
      bus(0, tss_pkg::IDX_TEST_MUX_A_SELECT_B, {3'b000, sb});
    end
    done_test("mux");
    bus(1, tss_pkg::IDX_RMUX, 8'h05);
    bus(1, tss_pkg::IDX_REF, 8'h80);
    expect_port(3'h1, 32'h0000_0015);
    bus(1, tss_pkg::IDX_REF, 8'hc0);
    expect_port(3'h1, 32'h0000_000d);
    bus(1, tss_pkg::IDX_REF, 8'h80);
    @(posedge sys_clk);
    wake <= 1'b1;
    @(posedge sys_clk);
    wake <= 1'b0;
    expect_port(3'h1, 32'h0000_0008);
    bus(0, tss_pkg::IDX_REF, 8'hc0);
    bus(0, tss_pkg::IDX_RMUX, 8'h00);
    done_test("reference");
    // busy lockout of the control byte
    bus(1, tss_pkg::IDX_CTRL, 8'hd0);
    bus(1, tss_pkg::IDX_CTRL, 8'h07);
    bus(0, tss_pkg::IDX_CTRL, 8'hd8);
    wait_cyc(BUSY + 2);
    bus(0, tss_pkg::IDX_CTRL, 8'hd0);
    expect_port(3'h1, 32'h0000_0068);
    mode <= '{sleep_mode: 1'b1, display_only_mode: 1'b0};
    expect_port(3'h1, 32'h0000_0028);
    mode <= '0;
    bus(1, tss_pkg::IDX_CTRL, 8'h50);
    expect_port(3'h1, 32'h0000_0048);
    wait_cyc(BUSY + 2);
    done_test("busy");
    clear_counts();
    bus(1, tss_pkg::IDX_CMD, 8'h40);
    bus(0, tss_pkg::IDX_CMD, 8'h40);
    wait_cyc(40);
    bus(0, tss_pkg::IDX_CMD, 8'h00);
    expect_port(3'h2, {16'd1, 16'd1});
    bus(0, tss_pkg::IDX_RES_HI, result[10:3]);
    bus(0, tss_pkg::IDX_RES_LO, {result[2:0], 5'h00});
    // start refused in both low-power modes
    for (int m = 1; m < 3; m++) begin
      mode <= tss_pkg::tss_mode_t'(2'(m));
      clear_counts();
      bus(1, tss_pkg::IDX_CMD, 8'h40);
      wait_cyc(40);
      bus(0, tss_pkg::IDX_CMD, 8'h00);
      expect_port(3'h2, 32'h0000_0000);
    end
    done_test("oneshot");
    // timed periods, alternate ones in sleep
    for (p = 1; p < 7; p++) begin
      mode <= (p % 2 == 1) ? 2'b10 : 2'b00;
      bus(1, tss_pkg::IDX_CTRL, 8'h10 | 8'(p));
      clear_counts();
      wait_cyc(((1 << (3 + p)) * TICK * 5) / 2 - 1);
      expect_port(3'h2, {16'd2, 16'd2});
    end
    // start refused while a period is set
    clear_counts();
    bus(1, tss_pkg::IDX_CMD, 8'h40);
    wait_cyc(40);
    expect_port(3'h2, 32'h0000_0000);
    done_test("period");
    bus(1, tss_pkg::IDX_CTRL, 8'h07);
    clear_counts();
    wait_cyc(150);
    expect_port(3'h3, 32'h0000_0001);
    done_test("continuous");
    final_report();
  end
endmodule : test_temp_sensor_sched_ctrl
